// [hdl/mate_map.svh]
`ifndef MATE_MAP_SVH
`define MATE_MAP_SVH
// data word offsets on the management port
`define MATE_OFF_W1     16'h0420
`define MATE_OFF_W2     16'h0424
`define MATE_OFF_W3     16'h0428
`define MATE_OFF_W4     16'h042c
// writable bits of each data word, reserved bits masked off
`define MATE_MASK_W1    32'hfc000007
`define MATE_MASK_W2    32'h80000007
`define MATE_MASK_W3    32'h007fffff
`define MATE_MASK_W4    32'hffffffff
// word 1 field positions
`define MATE_FIXED_BIT  31
`define MATE_SDROP_BIT  30
`define MATE_DDROP_BIT  29
`define MATE_AGE_HI     28
`define MATE_AGE_LO     26
`define MATE_MSTP_HI    2
`define MATE_MSTP_LO    0
// word 2 field positions
`define MATE_BYPASS_BIT 31
`define MATE_PORTS_HI   2
`define MATE_PORTS_LO   0
// word 3 field positions
`define MATE_FID_HI     22
`define MATE_FID_LO     16
`define MATE_MACH_HI    15
`define MATE_MACH_LO    0
// fixed table size and age reload value
`define MATE_FIX_DEPTH  16
`define MATE_AGE_RELOAD 3'h7
// reset value of every data word
`define MATE_WORD_RST   32'h00000000
`endif

// [hdl/mate_pkg.sv]
package mate_pkg;
   // one table entry, word 1 in the low bits
   typedef struct packed {
      logic [31:0] w4;
      logic [31:0] w3;
      logic [31:0] w2;
      logic [31:0] w1;
   } mate_entry_s;
   // fixed-table transfer sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_ACT, ST_FIN} mate_state_e;
endpackage

// [hdl/mate_mem_if.sv]
`timescale 1ns/100ps
interface mate_mem_if;
   logic                  we;
   logic [3:0]            idx;
   mate_pkg::mate_entry_s wdata;
   mate_pkg::mate_entry_s rdata;
   mate_pkg::mate_entry_s tbl [16];
   // sequencer side
   modport ctl (output we, output idx, output wdata,
                input rdata, input tbl);
   // storage side
   modport mem (input we, input idx, input wdata,
                output rdata, output tbl);
endinterface

// [hdl/mate_fixed_mem.sv]
`timescale 1ns/100ps
`include "mate_map.svh"
module mate_fixed_mem (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // port to the sequencer and the matchers
   mate_mem_if.mem  mif
);
   mate_pkg::mate_entry_s ram_reg [`MATE_FIX_DEPTH];

   // entries clear at reset so no stale valid flag matches
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `MATE_FIX_DEPTH; i++) begin
            ram_reg[i] <= '0;
         end
      end else if (mif.we) begin
         ram_reg[mif.idx] <= mif.wdata; // RL12
      end
   end

   // registered read port for host transfers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mif.rdata <= '0;
      end else begin
         mif.rdata <= ram_reg[mif.idx];
      end
   end

   // every entry is visible at once for parallel matching
   always_comb begin
      for (int i = 0; i < `MATE_FIX_DEPTH; i++) begin
         mif.tbl[i] = ram_reg[i];
      end
   end
endmodule

// [hdl/mate_top.sv]
`timescale 1ns/100ps
`include "mate_map.svh"
// How it works
// RL1: word 1 bit 31 marks a fixed entry; clear means learned and aged.
// RL2: bit 30 set drops a frame whose source address matches.
// RL3: bit 29 set drops a frame whose destination address matches.
// RL4: bits 28:26 are priority for fixed entries, age tally otherwise.
// RL5: learn or access reloads the tally; each aging pass decrements it.
// RL6: a learned entry with tally zero is invalid; fixed ones stay valid.
// RL7: word 1 bits 2:0 carry the spanning-tree group used in matching.
// RL8: word 2 bit 31 forwards regardless of destination port blocking.
// RL9: word 2 bits 2,1,0 select ports three, two and one.
// RL10: word 3 holds group id and upper address; word 4 lower address.
// RL11: a separate 16-entry fixed table, reached only indirectly.
// RL12: fixed table is host-written only and never aged.
// RL13: every destination lookup searches all address tables.
// RL14: a fixed hit in either table beats a learned hit.
// RL15: host loads data words then starts a write with op bit 0.
// RL16: host starts a read with op bit 1, then reads the data words.
// RL17: go clears itself at the end; a read fills the data words.
// RL18: only fixed-table entries with word 1 bit 31 set can match.
// RL19: lookup table op codes are 10 read, 11 search, 01 write.
// RL20: a lookup table read with no valid entry returns all zeros.
// RL21: reserved data bits read zero and ignore writes.
module mate_top (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   // management register port
   input  wire logic [15:0]           reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [31:0]           reg_wdata,
   output logic      [31:0]           reg_rdata,
   output logic                       reg_rvalid,
   // fixed-table transfer control
   input  wire logic                  go_req,
   input  wire logic                  tbl_sel,
   input  wire logic                  op_kind_bit,
   input  wire logic [3:0]            tbl_index,
   output logic                       go_done_bit,
   // lookup table engine data path
   input  wire logic                  lut_ret,
   input  wire logic                  lut_ret_valid,
   input  wire mate_pkg::mate_entry_s lut_ret_data,
   output mate_pkg::mate_entry_s      lut_entry,
   // forwarding lookup
   input  wire logic                  lk_req,
   input  wire logic [47:0]           da_mac,
   input  wire logic [6:0]            da_fid,
   input  wire logic [2:0]            da_mstp,
   input  wire logic [47:0]           sa_mac,
   input  wire logic                  alu_da_hit,
   input  wire logic [31:0]           alu_da_w1,
   input  wire logic [31:0]           alu_da_w2,
   input  wire logic                  alu_sa_hit,
   input  wire logic [31:0]           alu_sa_w1,
   output logic                       fwd_valid,
   output logic                       fwd_hit,
   output logic      [2:0]            fwd_ports,
   output logic                       fwd_bypass,
   output logic                       fwd_drop,
   output logic      [2:0]            fwd_prio,
   output logic                       src_drop,
   // entry aging
   input  wire logic                  age_req,
   input  wire logic                  age_pass,
   input  wire logic [31:0]           age_w1_in,
   output logic                       age_done,
   output logic      [31:0]           age_w1_out,
   output logic                       age_live
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   mate_pkg::mate_state_e st_reg;
   mate_pkg::mate_entry_s data_reg;
   logic                  op_reg;
   logic                  sel_reg;
   logic [3:0]            idx_reg;
   logic [15:0]           da_hit_v;
   logic [15:0]           sa_hit_v;
   logic [3:0]            first_da;
   logic                  fix_hit;
   logic                  alu_live;
   logic                  sa_alu_drop;
   logic [31:0]           res_w1;
   logic [31:0]           res_w2;
   logic                  res_hit;
   logic                  fin_rd;

   mate_mem_if mif ();

   mate_fixed_mem u_mem (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .mif      (mif)
   );

   // strip reserved bits so they always read back as zero
   function automatic mate_pkg::mate_entry_s clean(
      input mate_pkg::mate_entry_s e);
      mate_pkg::mate_entry_s r;
      r.w1 = e.w1 & `MATE_MASK_W1; // RL21
      r.w2 = e.w2 & `MATE_MASK_W2;
      r.w3 = e.w3 & `MATE_MASK_W3;
      r.w4 = e.w4 & `MATE_MASK_W4;
      return r;
   endfunction

   // transfer sequencer; a second go while busy is ignored
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= mate_pkg::ST_IDLE;
      end else begin
         case (st_reg)
            mate_pkg::ST_IDLE: begin
               if (go_req) begin
                  st_reg <= mate_pkg::ST_ACT;
               end
            end
            mate_pkg::ST_ACT: st_reg <= mate_pkg::ST_FIN;
            mate_pkg::ST_FIN: st_reg <= mate_pkg::ST_IDLE; // RL17
            default: st_reg <= mate_pkg::ST_IDLE;
         endcase
      end
   end

   // command fields are held for the whole transfer
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         op_reg  <= 1'b0;
         sel_reg <= 1'b0;
         idx_reg <= 4'h0;
      end else if (st_reg == mate_pkg::ST_IDLE && go_req) begin
         op_reg  <= op_kind_bit;
         sel_reg <= tbl_sel;
         idx_reg <= tbl_index;
      end
   end

   // go reads back set until the sequencer returns to idle
   assign go_done_bit = (st_reg != mate_pkg::ST_IDLE); // RL17

   // only table select 0 reaches the fixed table; op 0 writes
   assign mif.we    = (st_reg == mate_pkg::ST_ACT) && !sel_reg &&
                      !op_reg; // RL11
   assign mif.idx   = idx_reg;
   assign mif.wdata = data_reg;
   assign fin_rd    = (st_reg == mate_pkg::ST_FIN) && !sel_reg &&
                      op_reg;

   // data words: table read beats engine return beats host write
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_reg <= {4{`MATE_WORD_RST}};
      end else if (fin_rd) begin
         data_reg <= mif.rdata; // RL17
      end else if (lut_ret) begin
         data_reg <= lut_ret_valid ? clean(lut_ret_data) : '0; // RL20
      end else if (reg_wr) begin
         case (reg_addr)
            `MATE_OFF_W1: data_reg.w1 <= reg_wdata & `MATE_MASK_W1;
            `MATE_OFF_W2: data_reg.w2 <= reg_wdata & `MATE_MASK_W2;
            `MATE_OFF_W3: data_reg.w3 <= reg_wdata & `MATE_MASK_W3;
            `MATE_OFF_W4: data_reg.w4 <= reg_wdata & `MATE_MASK_W4;
            default: data_reg <= data_reg;
         endcase
      end
   end

   // the engine writes and searches from the same words
   assign lut_entry = data_reg; // RL10

   // register reads answer one cycle later; unmapped reads zero
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rvalid <= 1'b0;
         reg_rdata  <= 32'h00000000;
      end else begin
         reg_rvalid <= reg_rd;
         case (reg_addr)
            `MATE_OFF_W1: reg_rdata <= data_reg.w1;
            `MATE_OFF_W2: reg_rdata <= data_reg.w2;
            `MATE_OFF_W3: reg_rdata <= data_reg.w3;
            `MATE_OFF_W4: reg_rdata <= data_reg.w4;
            default: reg_rdata <= 32'h00000000;
         endcase
      end
   end

   // parallel compare of every fixed entry against both addresses
   for (genvar i = 0; i < `MATE_FIX_DEPTH; i++) begin : g_match
      assign da_hit_v[i] = mif.tbl[i].w1[`MATE_FIXED_BIT] && // RL18
         {mif.tbl[i].w3[`MATE_MACH_HI:`MATE_MACH_LO],
          mif.tbl[i].w4} == da_mac &&
         mif.tbl[i].w3[`MATE_FID_HI:`MATE_FID_LO] == da_fid &&
         mif.tbl[i].w1[`MATE_MSTP_HI:`MATE_MSTP_LO] == da_mstp; // RL7
      assign sa_hit_v[i] = mif.tbl[i].w1[`MATE_FIXED_BIT] &&
         mif.tbl[i].w1[`MATE_SDROP_BIT] && // RL2
         {mif.tbl[i].w3[`MATE_MACH_HI:`MATE_MACH_LO],
          mif.tbl[i].w4} == sa_mac;
   end

   // lowest index wins when two fixed entries match
   always_comb begin
      first_da = 4'h0;
      for (int i = `MATE_FIX_DEPTH - 1; i >= 0; i--) begin
         if (da_hit_v[i]) begin
            first_da = 4'(i);
         end
      end
   end

   // learned entries count only while their tally is nonzero
   assign fix_hit  = |da_hit_v; // RL13
   assign alu_live = alu_da_hit && (alu_da_w1[`MATE_FIXED_BIT] ||
      alu_da_w1[`MATE_AGE_HI:`MATE_AGE_LO] != 3'h0); // RL6
   assign sa_alu_drop = alu_sa_hit && alu_sa_w1[`MATE_SDROP_BIT] &&
      (alu_sa_w1[`MATE_FIXED_BIT] ||
       alu_sa_w1[`MATE_AGE_HI:`MATE_AGE_LO] != 3'h0);

   // fixed table first; a static engine hit still beats learned
   always_comb begin
      res_hit = 1'b1;
      res_w1  = 32'h00000000;
      res_w2  = 32'h00000000;
      if (fix_hit) begin
         res_w1 = mif.tbl[first_da].w1; // RL14
         res_w2 = mif.tbl[first_da].w2;
      end else if (alu_live) begin
         res_w1 = alu_da_w1;
         res_w2 = alu_da_w2;
      end else begin
         res_hit = 1'b0;
      end
   end

   // forwarding result, registered one cycle after the request
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fwd_valid  <= 1'b0;
         fwd_hit    <= 1'b0;
         fwd_ports  <= 3'h0;
         fwd_bypass <= 1'b0;
         fwd_drop   <= 1'b0;
         fwd_prio   <= 3'h0;
         src_drop   <= 1'b0;
      end else begin
         fwd_valid  <= lk_req;
         fwd_hit    <= lk_req && res_hit;
         fwd_ports  <= lk_req ?
            res_w2[`MATE_PORTS_HI:`MATE_PORTS_LO] : 3'h0; // RL9
         fwd_bypass <= lk_req && res_w2[`MATE_BYPASS_BIT]; // RL8
         fwd_drop   <= lk_req && res_w1[`MATE_DDROP_BIT]; // RL3
         fwd_prio   <= (lk_req && res_w1[`MATE_FIXED_BIT]) ?
            res_w1[`MATE_AGE_HI:`MATE_AGE_LO] : 3'h0; // RL4
         src_drop   <= lk_req && (|sa_hit_v || sa_alu_drop); // RL2
      end
   end

   // aging engine; fixed entries pass through untouched
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         age_done   <= 1'b0;
         age_w1_out <= 32'h00000000;
         age_live   <= 1'b0;
      end else begin
         age_done <= age_req;
         if (!age_req) begin
            age_live <= 1'b0;
         end else if (age_w1_in[`MATE_FIXED_BIT]) begin
            age_w1_out <= age_w1_in; // RL1
            age_live   <= 1'b1;
         end else if (age_pass) begin
            age_w1_out <= age_w1_in;
            if (age_w1_in[`MATE_AGE_HI:`MATE_AGE_LO] != 3'h0) begin
               age_w1_out[`MATE_AGE_HI:`MATE_AGE_LO] <=
                  age_w1_in[`MATE_AGE_HI:`MATE_AGE_LO] - 3'h1; // RL5
            end
            age_live <= age_w1_in[`MATE_AGE_HI:`MATE_AGE_LO] > 3'h1;
         end else begin
            age_w1_out <= age_w1_in;
            age_w1_out[`MATE_AGE_HI:`MATE_AGE_LO] <= `MATE_AGE_RELOAD;
            age_live <= 1'b1; // RL5
         end
      end
   end

   // checks
   go_clears_a: assert property ( // RL17
      (st_reg == mate_pkg::ST_IDLE && go_req) |=>
         go_done_bit ##1 go_done_bit ##1 !go_done_bit)
      else $error("go bit did not clear after two cycles");

   read_fills_a: assert property ( // RL17
      fin_rd |=> data_reg == $past(mif.rdata))
      else $error("fixed read did not fill the data words");

   rsv_zero_a: assert property ( // RL21
      (data_reg.w1 & ~`MATE_MASK_W1) == 32'h0 &&
      (data_reg.w2 & ~`MATE_MASK_W2) == 32'h0 &&
      (data_reg.w3 & ~`MATE_MASK_W3) == 32'h0)
      else $error("reserved data bits not zero");

   miss_zero_a: assert property ( // RL20
      (lut_ret && !lut_ret_valid && !fin_rd) |=> data_reg == '0)
      else $error("empty engine read left nonzero data");

   fixed_wins_a: assert property ( // RL14
      (lk_req && fix_hit) |=> fwd_hit &&
         fwd_ports == $past(mif.tbl[first_da].w2[2:0]))
      else $error("fixed hit did not decide forwarding");

   dead_entry_a: assert property ( // RL6
      (lk_req && !fix_hit && alu_da_hit && !alu_da_w1[31] &&
       alu_da_w1[28:26] == 3'h0) |=> !fwd_hit)
      else $error("aged-out entry was used");

   age_reload_a: assert property ( // RL5
      (age_req && !age_pass && !age_w1_in[31]) |=>
         age_w1_out[28:26] == `MATE_AGE_RELOAD && age_live)
      else $error("learn did not reload the tally");

   age_dec_a: assert property ( // RL5
      (age_req && age_pass && !age_w1_in[31] &&
       age_w1_in[28:26] != 3'h0) |=>
         age_w1_out[28:26] == $past(age_w1_in[28:26]) - 3'h1)
      else $error("aging pass did not decrement");

   fixed_kept_a: assert property ( // RL1
      (age_req && age_w1_in[31]) |=>
         age_w1_out == $past(age_w1_in) && age_live)
      else $error("fixed entry was aged");

   no_write_a: assert property ( // RL11
      mif.we |-> st_reg == mate_pkg::ST_ACT && !op_reg && !sel_reg)
      else $error("fixed table written outside a write");

   // the written entry must be visible to the matchers next cycle
   write_lands_a: assert property ( // RL11
      mif.we |=> mif.tbl[$past(mif.idx)] == $past(mif.wdata))
      else $error("fixed table write did not land");

   src_drop_a: assert property ( // RL2
      (lk_req && |sa_hit_v) |=> src_drop)
      else $error("source match did not drop");

   fixed_read_c: cover property (
      (st_reg == mate_pkg::ST_IDLE && go_req && op_kind_bit &&
       !tbl_sel) ##2 fin_rd);
   fixed_write_c: cover property (mif.we ##2 !go_done_bit);
   fwd_hit_c: cover property (lk_req && fix_hit && alu_live);
   age_out_c: cover property (age_req && age_pass &&
      age_w1_in[28:26] == 3'h1 && !age_w1_in[31]);
endmodule

// [test/mate_tb.sv]
`timescale 1ns/100ps
`include "mate_map.svh"
module testbench;
   // clock, reset and register port
   logic                  core_clk;
   logic                  arst_n;
   logic [15:0]           reg_addr;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [31:0]           reg_wdata;
   logic [31:0]           reg_rdata;
   logic                  reg_rvalid;
   // transfer control and engine path
   logic                  go_req;
   logic                  tbl_sel;
   logic                  op_kind_bit;
   logic [3:0]            tbl_index;
   logic                  go_done_bit;
   logic                  lut_ret;
   logic                  lut_ret_valid;
   mate_pkg::mate_entry_s lut_ret_data;
   mate_pkg::mate_entry_s lut_entry;
   // lookup and aging
   logic                  lk_req;
   logic [47:0]           da_mac;
   logic [6:0]            da_fid;
   logic [2:0]            da_mstp;
   logic [47:0]           sa_mac;
   logic                  alu_da_hit;
   logic [31:0]           alu_da_w1;
   logic [31:0]           alu_da_w2;
   logic                  alu_sa_hit;
   logic [31:0]           alu_sa_w1;
   logic                  fwd_valid;
   logic                  fwd_hit;
   logic [2:0]            fwd_ports;
   logic                  fwd_bypass;
   logic                  fwd_drop;
   logic [2:0]            fwd_prio;
   logic                  src_drop;
   logic                  age_req;
   logic                  age_pass;
   logic [31:0]           age_w1_in;
   logic                  age_done;
   logic [31:0]           age_w1_out;
   logic                  age_live;
   int                    err_count;
   int                    checks_done;

   mate_top DUT (.*);

   // free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // inputs move 1 ns after the edge so sampling never races
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick(); // an idle edge keeps back-to-back strobes apart
   endtask

   // read data is taken in the cycle the strobe comes back
   task automatic rd(input logic [15:0] a, input logic [31:0] exp,
                     input string what);
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      chk("rvalid", {31'h0, reg_rvalid}, 32'h1);
      chk(what, reg_rdata, exp);
      tick();
   endtask

   task automatic wr4(input logic [31:0] a, b, c, d);
      wr(`MATE_OFF_W1, a);
      wr(`MATE_OFF_W2, b);
      wr(`MATE_OFF_W3, c);
      wr(`MATE_OFF_W4, d);
   endtask

   task automatic rd4(input logic [31:0] a, b, c, d);
      rd(`MATE_OFF_W1, a, "word1");
      rd(`MATE_OFF_W2, b, "word2");
      rd(`MATE_OFF_W3, c, "word3");
      rd(`MATE_OFF_W4, d, "word4");
   endtask

   // a go is only offered once the previous transfer has ended
   task automatic go(input logic sel, op, input logic [3:0] idx);
      int n;
      n = 0;
      while (go_done_bit !== 1'b0 && n < 10) begin
         tick();
         n++;
      end
      if (n == 10) begin
         err_count++;
         $display("[FAIL] go idle expected 0 seen 1");
         results();
      end
      tbl_sel = sel;
      op_kind_bit = op;
      tbl_index = idx;
      go_req = 1'b1;
      tick();
      go_req = 1'b0;
      chk("go busy c1", {31'h0, go_done_bit}, 32'h1);
      tick();
      chk("go busy c2", {31'h0, go_done_bit}, 32'h1);
      tick();
      chk("go cleared", {31'h0, go_done_bit}, 32'h0);
   endtask

   // exp packs valid, hit, ports, bypass, drop, prio, src_drop
   task automatic look(input logic [47:0] da, input logic [6:0] filter_group_id,
                       input logic [47:0] sa, input logic dh,
                       input logic [31:0] d1, d2, input logic sh,
                       input logic [31:0] s1, input logic [10:0] exp);
      da_mac = da;
      da_fid = filter_group_id;
      da_mstp = 3'h5;
      sa_mac = sa;
      alu_da_hit = dh;
      alu_da_w1 = d1;
      alu_da_w2 = d2;
      alu_sa_hit = sh;
      alu_sa_w1 = s1;
      lk_req = 1'b1;
      tick();
      lk_req = 1'b0;
      chk("forward", {21'h0, fwd_valid, fwd_hit, fwd_ports, fwd_bypass,
          fwd_drop, fwd_prio, src_drop}, {21'h0, exp});
      tick();
   endtask

   task automatic age(input logic p, input logic [31:0] w, ew,
                      input logic live);
      age_pass = p;
      age_w1_in = w;
      age_req = 1'b1;
      tick();
      age_req = 1'b0;
      chk("age word", age_w1_out, ew);
      chk("age flags", {30'h0, age_done, age_live},
          {30'h0, 1'b1, live});
      tick();
   endtask

   // main sequence
   initial begin
      logic [15:0] offs [4];
      logic [31:0] msks [4];
      offs = '{`MATE_OFF_W1, `MATE_OFF_W2, `MATE_OFF_W3, `MATE_OFF_W4};
      msks = '{`MATE_MASK_W1, `MATE_MASK_W2, `MATE_MASK_W3, `MATE_MASK_W4};
      {arst_n, reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
      {go_req, tbl_sel, op_kind_bit, tbl_index} = '0;
      {lut_ret, lut_ret_valid, lut_ret_data, lk_req} = '0;
      {da_mac, da_fid, da_mstp, sa_mac, alu_da_hit} = '0;
      {alu_da_w1, alu_da_w2, alu_sa_hit, alu_sa_w1} = '0;
      {age_req, age_pass, age_w1_in} = '0;
      err_count = 0;
      checks_done = 0;
      repeat (2) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      rd4(0, 0, 0, 0);
      rd(16'h0430, 32'h0, "unmapped");
      $display("test reset values done");
      // reserved bits stay zero even when written with ones
      for (int i = 0; i < 4; i++) begin
         wr(offs[i], 32'hffffffff);
         rd(offs[i], msks[i], "masked word");
      end
      $display("test reserved bits done");
      // invalid entry at index 3, valid one at index 15
      wr4(32'h34000005, 32'h00000002, 32'h002a1234, 32'h89abcdef);
      go(1'b0, 1'b0, 4'h3);
      wr4(32'hb4000005, 32'h80000005, 32'h002a1234, 32'h89abcdef);
      go(1'b0, 1'b0, 4'hf);
      wr4(0, 0, 0, 0);
      go(1'b0, 1'b1, 4'hf);
      rd4(32'hb4000005, 32'h80000005, 32'h002a1234, 32'h89abcdef);
      go(1'b0, 1'b1, 4'h3);
      rd(`MATE_OFF_W1, 32'h34000005, "index 3 word1");
      go(1'b0, 1'b1, 4'hf);
      go(1'b1, 1'b1, 4'h0);
      rd(`MATE_OFF_W1, 32'hb4000005, "other table");
      $display("test fixed table done");
      // fixed hit beats a learned engine hit; invalid index 3 skipped
      look(48'h123489abcdef, 7'h2a, 48'h0, 1'b1, 32'h1c000000, 32'h2,
           1'b0, 32'h0, 11'b1_1_101_1_1_101_0);
      // group id mismatch falls to the learned engine entry
      look(48'h123489abcdef, 7'h2b, 48'h1, 1'b1, 32'h1c000000, 32'h2,
           1'b1, 32'h5c000000, 11'b1_1_010_0_0_000_1);
      look(48'h1, 7'h0, 48'h1, 1'b1, 32'h00000000, 32'h4,
           1'b1, 32'h1c000000, 11'b1_0_000_0_0_000_0);
      look(48'h2, 7'h0, 48'h1, 1'b1, 32'hbc000000, 32'h80000001,
           1'b0, 32'h0, 11'b1_1_001_1_1_111_0);
      look(48'h2, 7'h0, 48'h1, 1'b0, 32'h0, 32'h0,
           1'b0, 32'h0, 11'b1_0_000_0_0_000_0);
      $display("test lookup done");
      age(1'b1, 32'h04000003, 32'h00000003, 1'b0);
      age(1'b1, 32'h14000000, 32'h10000000, 1'b1);
      age(1'b0, 32'h00000003, {1'b0, 2'b0, `MATE_AGE_RELOAD, 26'h3},
          1'b1);
      age(1'b1, 32'h88000001, 32'h88000001, 1'b1);
      $display("test aging done");
      // engine return fills the data words, or zeros them
      lut_ret_data = {32'h01020304, 32'h00550a0b, 32'h80000003,
                      32'h9c000002};
      lut_ret_valid = 1'b1;
      lut_ret = 1'b1;
      tick();
      lut_ret = 1'b0;
      rd4(32'h9c000002, 32'h80000003, 32'h00550a0b, 32'h01020304);
      chk("engine view", lut_entry.w4, 32'h01020304);
      lut_ret_valid = 1'b0;
      lut_ret = 1'b1;
      tick();
      lut_ret = 1'b0;
      rd4(0, 0, 0, 0);
      $display("test engine return done");
      results();
   end
endmodule
